// File: rtl/ltj_config.sv
// Purpose: termination, jitter attenuator and transmit config registers
// Assumes: host port writes one byte per strobe; pins are asynchronous
// Notes: decoded controls and conditioned transmit rails are registered
//
// How it works
// [R01] tx termination 000..011 picks internal impedance
// [R02] tx termination 1xx picks external, E1 only
// [R03] rx termination 000..011 picks internal impedance
// [R04] rx termination 1xx picks external resistors
// [R05] limit bit: 0 normal, 1 limit; resets 1
// [R06] placement 01 transmit, 11 receive, else unused
// [R07] depth 00=128, 01=64, 1x=32 bits
// [R08] bandwidth bit picks corner per line standard
// [R09] power-down bit stops transmitter, driver high impedance
// [R10] invert bit makes transmit data active low
// [R11] edge bit: 0 falling, 1 rising sample
// [R12] mode 00 HDB3/B8ZS encoder, single rail
// [R13] mode 01 AMI encoder, single rail
// [R14] mode 1x bypasses encoder, dual rail input
// [R15] line standard bit: 0 E1, 1 T1/J1
// [R16] soft reset write restores defaults except standard
// [R17] reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
module ltj_config (
   input wire logic clk_sys,
   input wire logic resetn,
   // host register port
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [7:0] host_rdata,
   // transmit data pins
   input wire logic tx_single_rail_in,
   input wire logic tx_positive_rail_in,
   input wire logic tx_negative_rail_in,
   // decoded termination controls
   output logic [1:0] tx_term_impedance,
   output logic tx_term_external,
   output logic [1:0] rx_term_impedance,
   output logic rx_term_external,
   // decoded jitter attenuator controls
   output logic jitter_limit_mode,
   output logic jitter_in_tx_path,
   output logic jitter_in_rx_path,
   output logic [7:0] jitter_depth_bits,
   output logic jitter_bandwidth_sel,
   output logic [9:0] jitter_corner_centihz,
   output logic line_standard_sel,
   // decoded transmit controls
   output logic tx_power_down,
   output logic tx_driver_hiz,
   output logic tx_data_invert,
   output logic tx_clock_edge_sel,
   output logic tx_enc_hdb3,
   output logic tx_enc_ami,
   output logic tx_enc_bypass,
   // conditioned transmit rails
   output logic tx_pos_data,
   output logic tx_neg_data
);

   ////////////////////////////////////////////////////////////////////////////////
   // register storage and write decode

   logic [7:0] global_cfg_reg;
   logic [7:0] line_termination_select_reg;
   logic [7:0] jitter_attenuator_config_reg;
   logic [7:0] transmit_config_zero_reg;

   wire wr_soft_reset = host_wr && (host_addr == ltj_pkg::ADDR_SOFT_RESET);
   wire wr_global = host_wr && (host_addr == ltj_pkg::ADDR_GLOBAL_CFG);
   wire wr_term = host_wr && (host_addr == ltj_pkg::ADDR_LINE_TERM);
   wire wr_jitter = host_wr && (host_addr == ltj_pkg::ADDR_JITTER_CFG);
   wire wr_tx = host_wr && (host_addr == ltj_pkg::ADDR_TX_CFG0);

   // masked next values; reserved bits never get stored
   wire [7:0] global_cfg_next = wr_global ? (host_wdata & ltj_pkg::MASK_GLOBAL_CFG)
                                          : global_cfg_reg; // R17
   wire [7:0] term_next = wr_soft_reset ? ltj_pkg::RST_LINE_TERM
                        : wr_term ? (host_wdata & ltj_pkg::MASK_LINE_TERM) // R17
                        : line_termination_select_reg; // R16
   wire [7:0] jitter_next = wr_soft_reset ? ltj_pkg::RST_JITTER_CFG
                          : wr_jitter ? (host_wdata & ltj_pkg::MASK_JITTER_CFG) // R17
                          : jitter_attenuator_config_reg; // R16
   wire [7:0] tx_cfg_next = wr_soft_reset ? ltj_pkg::RST_TX_CFG0
                          : wr_tx ? (host_wdata & ltj_pkg::MASK_TX_CFG0) // R17
                          : transmit_config_zero_reg; // R16

   // line standard survives a soft reset so the clocking does not move under software
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         global_cfg_reg <= ltj_pkg::RST_GLOBAL_CFG;
         line_termination_select_reg <= ltj_pkg::RST_LINE_TERM;
         jitter_attenuator_config_reg <= ltj_pkg::RST_JITTER_CFG; // R05
         transmit_config_zero_reg <= ltj_pkg::RST_TX_CFG0;
      end else begin
         global_cfg_reg <= global_cfg_next; // R16
         line_termination_select_reg <= term_next;
         jitter_attenuator_config_reg <= jitter_next;
         transmit_config_zero_reg <= tx_cfg_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path: unmapped addresses and the write-only reset register read zero

   wire [7:0] rd_mux = (host_addr == ltj_pkg::ADDR_GLOBAL_CFG) ? global_cfg_reg
                     : (host_addr == ltj_pkg::ADDR_LINE_TERM) ? line_termination_select_reg
                     : (host_addr == ltj_pkg::ADDR_JITTER_CFG) ? jitter_attenuator_config_reg
                     : (host_addr == ltj_pkg::ADDR_TX_CFG0) ? transmit_config_zero_reg
                     : 8'h00;

   // read data holds its last value between reads
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) host_rdata <= 8'h00;
      else if (host_rd) host_rdata <= rd_mux; // R17
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field decode, computed from next values so outputs track the registers

   wire std_t1 = global_cfg_next[ltj_pkg::LINE_STD_BIT]; // R15
   wire [2:0] tx_term_f = term_next[ltj_pkg::TX_TERM_LSB +: 3];
   wire [2:0] rx_term_f = term_next[ltj_pkg::RX_TERM_LSB +: 3];
   // external transmit resistors only make sense in E1; T1/J1 stays internal
   wire tx_ext_d = tx_term_f[2] & ~std_t1; // R02
   wire [1:0] tx_imp_d = tx_term_f[2] ? 2'h0 : tx_term_f[1:0]; // R01
   wire rx_ext_d = rx_term_f[2]; // R04
   wire [1:0] rx_imp_d = rx_term_f[2] ? 2'h0 : rx_term_f[1:0]; // R03

   wire [1:0] jit_place_f = jitter_next[ltj_pkg::JIT_PLACE_LSB +: 2];
   wire [1:0] jit_depth_f = jitter_next[ltj_pkg::JIT_DEPTH_LSB +: 2];
   wire jit_bw_f = jitter_next[ltj_pkg::JIT_BW_BIT];
   wire jit_tx_d = (jit_place_f == ltj_pkg::JIT_PLACE_TX); // R06
   wire jit_rx_d = (jit_place_f == ltj_pkg::JIT_PLACE_RX); // R06
   wire [7:0] jit_depth_d = jit_depth_f[1] ? ltj_pkg::JIT_DEPTH_32
                          : jit_depth_f[0] ? ltj_pkg::JIT_DEPTH_64
                          : ltj_pkg::JIT_DEPTH_128; // R07
   wire [9:0] jit_corner_d = jit_bw_f ? (std_t1 ? ltj_pkg::JIT_BW_T1_NARROW
                                                : ltj_pkg::JIT_BW_E1_NARROW)
                                      : (std_t1 ? ltj_pkg::JIT_BW_T1_WIDE
                                                : ltj_pkg::JIT_BW_E1_WIDE); // R08

   wire [1:0] tx_mode_f = tx_cfg_next[ltj_pkg::TX_MODE_LSB +: 2];
   wire tx_off_d = tx_cfg_next[ltj_pkg::TX_OFF_BIT]; // R09
   wire tx_inv_d = tx_cfg_next[ltj_pkg::TX_INV_BIT]; // R10
   wire tx_edge_d = tx_cfg_next[ltj_pkg::TX_EDGE_BIT]; // R11
   wire enc_hdb3_d = (tx_mode_f == ltj_pkg::TX_MODE_HDB3); // R12
   wire enc_ami_d = (tx_mode_f == ltj_pkg::TX_MODE_AMI); // R13
   wire bypass_d = tx_mode_f[1]; // R14

   // decoded controls
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_term_impedance <= 2'h0;
         tx_term_external <= 1'b0;
         rx_term_impedance <= 2'h0;
         rx_term_external <= 1'b0;
         jitter_limit_mode <= ltj_pkg::RST_JITTER_CFG[ltj_pkg::JIT_LIMIT_BIT];
         jitter_in_tx_path <= 1'b0;
         jitter_in_rx_path <= 1'b0;
         jitter_depth_bits <= ltj_pkg::JIT_DEPTH_128;
         jitter_bandwidth_sel <= 1'b0;
         jitter_corner_centihz <= ltj_pkg::JIT_BW_E1_WIDE;
         line_standard_sel <= 1'b0;
      end else begin
         tx_term_impedance <= tx_imp_d; // R01
         tx_term_external <= tx_ext_d; // R02
         rx_term_impedance <= rx_imp_d; // R03
         rx_term_external <= rx_ext_d; // R04
         jitter_limit_mode <= jitter_next[ltj_pkg::JIT_LIMIT_BIT]; // R05
         jitter_in_tx_path <= jit_tx_d; // R06
         jitter_in_rx_path <= jit_rx_d; // R06
         jitter_depth_bits <= jit_depth_d; // R07
         jitter_bandwidth_sel <= jit_bw_f; // R08
         jitter_corner_centihz <= jit_corner_d; // R08
         line_standard_sel <= std_t1; // R15
      end
   end

   // transmit controls
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_power_down <= 1'b0;
         tx_driver_hiz <= 1'b0;
         tx_data_invert <= 1'b0;
         tx_clock_edge_sel <= 1'b0;
         tx_enc_hdb3 <= 1'b1;
         tx_enc_ami <= 1'b0;
         tx_enc_bypass <= 1'b0;
      end else begin
         tx_power_down <= tx_off_d; // R09
         tx_driver_hiz <= tx_off_d; // R09
         tx_data_invert <= tx_inv_d; // R10
         tx_clock_edge_sel <= tx_edge_d; // R11
         tx_enc_hdb3 <= enc_hdb3_d; // R12
         tx_enc_ami <= enc_ami_d; // R13
         tx_enc_bypass <= bypass_d; // R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit pin conditioning: synchronise, pick rail source, apply polarity

   wire [2:0] pin_raw = {tx_negative_rail_in, tx_positive_rail_in, tx_single_rail_in};
   wire [2:0] pin_sync;

   // one filtered synchroniser per transmit data pin
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin_sync
         ltj_sync3 u_sync (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .pin_in(pin_raw[gi]),
            .pin_out(pin_sync[gi])
         );
      end
   endgenerate

   // single rail feeds only the positive side; the encoder downstream makes marks
   wire pos_src = bypass_d ? pin_sync[1] : pin_sync[0]; // R14
   wire neg_src = bypass_d ? pin_sync[2] : 1'b0; // R12
   // a powered-down transmitter forwards nothing, so the driver sees idle
   wire pos_d = tx_off_d ? 1'b0 : (pos_src ^ tx_inv_d); // R10
   wire neg_d = (tx_off_d || !bypass_d) ? 1'b0 : (neg_src ^ tx_inv_d); // R10

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tx_pos_data <= 1'b0;
         tx_neg_data <= 1'b0;
      end else begin
         tx_pos_data <= pos_d; // R09
         tx_neg_data <= neg_d;
      end
   end

endmodule : ltj_config
`default_nettype wire

// File: rtl/ltj_pkg.sv
// Purpose: shared constants for the termination / jitter / transmit config slice
// Assumes: 8-bit host register port, one register per byte address
// Notes: field positions, reset values and masks live here only
package ltj_pkg;
   // register addresses
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
   localparam logic [7:0] ADDR_GLOBAL_CFG = 8'h02;
   localparam logic [7:0] ADDR_LINE_TERM = 8'h03;
   localparam logic [7:0] ADDR_JITTER_CFG = 8'h04;
   localparam logic [7:0] ADDR_TX_CFG0 = 8'h05;
   // values after reset
   localparam logic [7:0] RST_GLOBAL_CFG = 8'h00;
   localparam logic [7:0] RST_LINE_TERM = 8'h00;
   localparam logic [7:0] RST_JITTER_CFG = 8'h20;
   localparam logic [7:0] RST_TX_CFG0 = 8'h00;
   // writable bits; everything else is reserved and reads zero
   localparam logic [7:0] MASK_GLOBAL_CFG = 8'h04;
   localparam logic [7:0] MASK_LINE_TERM = 8'h3F;
   localparam logic [7:0] MASK_JITTER_CFG = 8'h3F;
   localparam logic [7:0] MASK_TX_CFG0 = 8'h1F;
   // field positions
   localparam int LINE_STD_BIT = 2;
   localparam int TX_TERM_LSB = 3;
   localparam int RX_TERM_LSB = 0;
   localparam int JIT_LIMIT_BIT = 5;
   localparam int JIT_PLACE_LSB = 3;
   localparam int JIT_DEPTH_LSB = 1;
   localparam int JIT_BW_BIT = 0;
   localparam int TX_OFF_BIT = 4;
   localparam int TX_INV_BIT = 3;
   localparam int TX_EDGE_BIT = 2;
   localparam int TX_MODE_LSB = 0;
   // placement and mode codes
   localparam logic [1:0] JIT_PLACE_TX = 2'h1;
   localparam logic [1:0] JIT_PLACE_RX = 2'h3;
   localparam logic [1:0] TX_MODE_HDB3 = 2'h0;
   localparam logic [1:0] TX_MODE_AMI = 2'h1;
   // buffer depths in bits
   localparam logic [7:0] JIT_DEPTH_128 = 8'h80;
   localparam logic [7:0] JIT_DEPTH_64 = 8'h40;
   localparam logic [7:0] JIT_DEPTH_32 = 8'h20;
   // jitter corner in units of 0.01 Hz
   localparam logic [9:0] JIT_BW_E1_WIDE = 10'h2A8;
   localparam logic [9:0] JIT_BW_T1_WIDE = 10'h1F4;
   localparam logic [9:0] JIT_BW_E1_NARROW = 10'h05A;
   localparam logic [9:0] JIT_BW_T1_NARROW = 10'h07D;
endpackage : ltj_pkg

// File: rtl/ltj_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: async input, clk_sys domain
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ltj_sync3 (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pin_in,
   output logic pin_out
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) pin_out <= s3_reg; // hold on disagreement
      end
   end
endmodule : ltj_sync3
`default_nettype wire

// File: test/ltj_config_sva.sv
// Purpose: port assertions for ltj_config
// Assumes: one clock, resetn async active low
// Notes: write checks look one edge after the strobe
`timescale 1ns/1ps
`default_nettype none
module ltj_config_chk (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_wdata,
   input wire logic host_wr,
   input wire logic tx_term_external,
   input wire logic line_standard_sel,
   input wire logic jitter_limit_mode,
   input wire logic jitter_in_tx_path,
   input wire logic jitter_in_rx_path,
   input wire logic [7:0] jitter_depth_bits,
   input wire logic [9:0] jitter_corner_centihz,
   input wire logic tx_power_down,
   input wire logic tx_enc_hdb3,
   input wire logic tx_enc_ami,
   input wire logic tx_enc_bypass,
   input wire logic tx_pos_data,
   input wire logic tx_neg_data
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // host writes that the checks key on
   sequence wr_rst_s; host_wr && host_addr == 8'h01; endsequence
   sequence wr_term_s; host_wr && host_addr == 8'h03; endsequence
   sequence wr_jit_s; host_wr && host_addr == 8'h04; endsequence
   sequence wr_tx_s; host_wr && host_addr == 8'h05; endsequence
   ////////////////////////////////////////////////////////////////////////////////
   mode_onehot_a: assert property ($onehot({tx_enc_hdb3, tx_enc_ami, tx_enc_bypass}))
      else $error("mode not one-hot");
   tx_write_a: assert property (wr_tx_s |=> tx_power_down == $past(host_wdata[4])
      && {tx_enc_ami, tx_enc_bypass} == {$past(host_wdata[1:0]) == 2'h1, $past(host_wdata[1])})
      else $error("tx config decode");
   power_quiet_a: assert property (tx_power_down [*2] |-> !tx_pos_data && !tx_neg_data)
      else $error("rails live in power-down");
   jit_place_a: assert property (wr_jit_s |=> {jitter_in_tx_path, jitter_in_rx_path} ==
      {$past(host_wdata[4:3]) == 2'h1, $past(host_wdata[4:3]) == 2'h3}) else $error("placement");
   jit_depth_a: assert property (wr_jit_s |=> jitter_limit_mode == $past(host_wdata[5])
      && jitter_depth_bits ==
      ($past(host_wdata[2]) ? 8'h20 : $past(host_wdata[1]) ? 8'h40 : 8'h80)) else $error("depth");
   jit_corner_a: assert property (wr_jit_s |=> jitter_corner_centihz == (line_standard_sel ?
      ($past(host_wdata[0]) ? 10'h07D : 10'h1F4) : ($past(host_wdata[0]) ? 10'h05A : 10'h2A8)))
      else $error("corner");
   soft_reset_a: assert property (wr_rst_s |=> jitter_limit_mode && tx_enc_hdb3
      && jitter_depth_bits == 8'h80 && !tx_power_down && $stable(line_standard_sel))
      else $error("soft reset");
   tx_term_a: assert property (wr_term_s |=> tx_term_external ==
      ($past(host_wdata[5]) && !line_standard_sel)) else $error("tx termination");
endmodule : ltj_config_chk
bind ltj_config ltj_config_chk chk_u (.*);
`default_nettype wire

// File: test/ltj_config_tb.sv
// Purpose: directed host-port test of ltj_config
// Assumes: strobes driven at the falling edge, one access per two cycles
// Notes: rail latency is waited out, not counted edge by edge
`timescale 1ns/1ps
`default_nettype none
module ltj_config_tb;
   logic clk_sys, resetn, wr_en, rd_en, p_s, p_p, p_n, t_ext, r_ext, lim, jit_tx, jit_rx, bw;
   logic std, pd, hiz, inv, edg, m_hdb3, m_ami, m_byp, pos, neg;
   logic [7:0] addr, wdata, rdata, depth;
   logic [1:0] t_imp, r_imp;
   logic [9:0] corner;
   int mismatches = 0, total_checks = 0, cycles = 0;
   // read masks by address; rail cases as config, pins {s,p,n}, rails {pos,neg}
   logic [7:0] msk[7] = '{8'h00, 8'h00, 8'h04, 8'h3F, 8'h3F, 8'h1F, 8'h00};
   logic [7:0] rc[6] = '{8'h00, 8'h08, 8'h01, 8'h02, 8'h0A, 8'h12};
   logic [2:0] rp[6] = '{3'h4, 3'h4, 3'h3, 3'h1, 3'h1, 3'h6};
   logic [1:0] re[6] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
   ltj_config dut_u (.clk_sys(clk_sys), .resetn(resetn), .host_addr(addr), .host_wdata(wdata),
      .host_wr(wr_en), .host_rd(rd_en), .host_rdata(rdata), .tx_single_rail_in(p_s),
      .tx_positive_rail_in(p_p), .tx_negative_rail_in(p_n), .tx_term_impedance(t_imp),
      .tx_term_external(t_ext), .rx_term_impedance(r_imp), .rx_term_external(r_ext),
      .jitter_limit_mode(lim), .jitter_in_tx_path(jit_tx), .jitter_in_rx_path(jit_rx),
      .jitter_depth_bits(depth), .jitter_bandwidth_sel(bw), .jitter_corner_centihz(corner),
      .line_standard_sel(std), .tx_power_down(pd), .tx_driver_hiz(hiz), .tx_data_invert(inv),
      .tx_clock_edge_sel(edg), .tx_enc_hdb3(m_hdb3), .tx_enc_ami(m_ami), .tx_enc_bypass(m_byp),
      .tx_pos_data(pos), .tx_neg_data(neg));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard; the run needs under 2000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 5000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one access; strobe held a full cycle so it never toggles twice in a step
   task automatic bus(input logic w, input logic [7:0] a, d, exp);
      @(negedge clk_sys);
      addr = a;
      wdata = d;
      wr_en = w;
      rd_en = !w;
      @(negedge clk_sys);
      wr_en = 1'b0;
      rd_en = 1'b0;
      if (!w) chk(rdata, exp);
   endtask : bus
   task automatic dflt(input logic [7:0] g);
      bus(1'b0, 8'h02, 8'h00, g);
      bus(1'b0, 8'h03, 8'h00, 8'h00);
      bus(1'b0, 8'h04, 8'h00, 8'h20);
      bus(1'b0, 8'h05, 8'h00, 8'h00);
      chk({std, m_hdb3, depth}, {g[2], 1'b1, 8'h80});
   endtask : dflt
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      {resetn, wr_en, rd_en, p_s, p_p, p_n} = 6'h00;
      {addr, wdata} = 16'h0000;
      repeat (16) @(negedge clk_sys);
      resetn = 1'b1;
      dflt(8'h00);
      // all ones everywhere, unmapped place included
      for (int i = 1; i < 7; i++) begin
         bus(1'b1, i[7:0], 8'hFF, 8'h00);
         bus(1'b0, i[7:0], 8'h00, msk[i]);
      end
      // every code of all three registers, in E1 then T1/J1
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, 8'h02, {5'h00, s[0], 2'h0}, 8'h00);
         chk(std, s[0]);
         for (int j = 0; j < 64; j++) begin
            bus(1'b1, 8'h03, j[7:0], 8'h00);
            bus(1'b1, 8'h04, j[7:0], 8'h00);
            bus(1'b1, 8'h05, j[7:0], 8'h00);
            chk({t_ext, t_imp}, {j[5] & ~s[0], j[5] ? 2'h0 : j[4:3]});
            chk({r_ext, r_imp}, {j[2], j[2] ? 2'h0 : j[1:0]});
            chk({lim, jit_tx, jit_rx}, {j[5], j[4:3] == 2'h1, j[4:3] == 2'h3});
            chk({bw, depth}, {j[0], j[2] ? 8'h20 : j[1] ? 8'h40 : 8'h80});
            chk(corner, s ? (j[0] ? 10'h07D : 10'h1F4) : (j[0] ? 10'h05A : 10'h2A8));
            chk({pd, hiz, inv, edg}, {j[4], j[4], j[3], j[2]});
            chk({m_hdb3, m_ami, m_byp}, {j[1:0] == 2'h0, j[1:0] == 2'h1, j[1]});
         end
      end
      // rails per mode, invert and power-down
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, 8'h05, rc[k], 8'h00);
         {p_s, p_p, p_n} = rp[k];
         repeat (6) @(negedge clk_sys);
         chk({pos, neg}, re[k]);
      end
      bus(1'b1, 8'h01, 8'h00, 8'h00);
      dflt(8'h04);
      summarize();
   end
endmodule : ltj_config_tb
`default_nettype wire
